//--- rtl/flbp_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// - Entry: three unlock writes, mode-dependent addresses
// - Leave a set with 90 then 00
// - Lock register program: A0 then contents
// - Register and password reads are plain reads
// - Each password program stores one portion
// - Password readout: addresses 00 up to 07/03
// - Byte unlock: 25, 03, eight portions, 29
// - Word unlock: 25, 03, four words, 29
// - Nonvolatile bit set: A0 then 00 in block
// - Unlock attempts spaced by six microseconds
module flbp_ctrl #(
  parameter int SETUP_CYC = 1,
  parameter int PULSE_CYC = 3,
  parameter int HOLD_CYC = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Flash pins
  output logic [23:0] flash_addr_o,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [15:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic flash_byte_n_o
);
  import flbp_pkg::*;
  // Byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction
  // Bus cycle for a given step of an operation
  function automatic flbp_cyc_type step_of(input flbp_op_type op, input logic [3:0] idx,
                                           input logic wm, input logic [23:0] ad,
                                           input logic [15:0] wd, input logic [7:0] code,
                                           input logic [63:0] pw);
    flbp_cyc_type s;
    logic [23:0] u1;
    logic [23:0] u2;
    logic [3:0] n;
    logic [2:0] k;
    u1 = wm ? U1_X16 : U1_X8;
    u2 = wm ? U2_X16 : U2_X8;
    n = wm ? PWD_N_X16 : PWD_N_X8;
    k = 3'(idx - 4'h2);
    s = '{addr: ADDR_X, data: D_00, we: 1'b1, last: 1'b0};
    unique case (op)
      // Unlock pair then set code, upper byte zero
      OP_ENTER: begin
        s.addr = (idx == 4'h1) ? u2 : u1;
        s.data = (idx == 4'h0) ? D_AA : (idx == 4'h1) ? D_55 : {8'h00, code};
        s.last = (idx == 4'h2);
      end
      // Exit pair to don't-care address
      OP_EXIT: begin
        s.data = (idx == 4'h0) ? D_90 : D_00;
        s.last = (idx == 4'h1);
      end
      // A0 then target address and value
      OP_PROG: begin
        s.addr = (idx == 4'h0) ? ADDR_X : ad;
        s.data = (idx == 4'h0) ? D_A0 : wd;
        s.last = (idx == 4'h1);
      end
      // Plain read, no command code
      OP_READ: begin
        s.addr = ad;
        s.we = 1'b0;
        s.last = 1'b1;
      end
      // Clear-all pair
      OP_CLRALL: begin
        s.data = (idx == 4'h0) ? D_80 : D_30;
        s.last = (idx == 4'h1);
      end
      // 25, 03, portions in address order, then 29
      OP_UNLOCK: begin
        s.data = (idx == 4'h0) ? D_25 : (idx == 4'h1) ? D_03 : D_29;
        s.last = (idx == n + 4'h2);
        if (idx > 4'h1 && idx < n + 4'h2) begin
          s.addr = {21'h00_0000, k};
          s.data = wm ? pw[{k[1:0], 4'h0} +: 16] : {8'h00, pw[{k, 3'b000} +: 8]};
        end
      end
      // AA to address zero, 55 at second unlock address, 90 at first unlock address, 00 anywhere
      OP_EXTEXIT: begin
        s.addr = (idx == 4'h1) ? u2 : (idx == 4'h2) ? u1 : ADDR_X;
        s.data = (idx == 4'h0) ? D_AA : (idx == 4'h1) ? D_55 : (idx == 4'h2) ? D_90 : D_00;
        s.last = (idx == 4'h3);
      end
      default: s.last = 1'b1;
    endcase
    return s;
  endfunction
  // Software-visible registers
  logic [31:0] ctrl_q, ctrl_d;
  logic [23:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [63:0] pwd_q, pwd_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  // Sequencer state
  flbp_state_type st_q, st_d;
  flbp_op_type op_q, op_d;
  logic [7:0] code_q, code_d;
  logic [3:0] idx_q, idx_d;
  logic start_q, start_d;
  logic [15:0] rdata_q, rdata_d;
  logic set_q, set_d, ext_q, ext_d, refused_q, refused_d;
  logic [GAP_W-1:0] gap_q, gap_d;
  // Engine handshake
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic wb_req;
  logic cmd_wr;
  flbp_cyc_type cur;
  logic [31:0] status;
  logic [31:0] reg_word, merged;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign cmd_wr = wb_req && wb_we_i && (wb_adr_i == REG_CMD) && wb_sel_i[0];
  assign cur = step_of(op_q, idx_q, ctrl_q[CTRL_WORD_BIT], addr_q, wdata_q, code_q, pwd_q);
  // Bit 4 mirrors data line 0 of the last read: protection status
  assign status = {27'h000_0000, rdata_q[0], refused_q, ext_q, set_q, st_q != S_IDLE};
  // Register writes and read-back
  always_comb begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    pwd_d = pwd_q;
    ack_d = wb_req;
    // Current word at the addressed offset, for read-back and lane merging
    unique case (wb_adr_i)
      REG_CTRL: reg_word = ctrl_q;
      REG_CMD: reg_word = {16'h0000, code_q, 5'h00, op_q};
      REG_ADDR: reg_word = {8'h00, addr_q};
      REG_WDATA: reg_word = {16'h0000, wdata_q};
      REG_STATUS: reg_word = status;
      REG_RDATA: reg_word = {16'h0000, rdata_q};
      REG_PWD_LO: reg_word = pwd_q[31:0];
      REG_PWD_HI: reg_word = pwd_q[63:32];
      default: reg_word = 32'h0000_0000;
    endcase
    merged = lane_merge(reg_word, wb_dat_i, wb_sel_i);
    dat_d = wb_req ? reg_word : dat_q;
    if (wb_req && wb_we_i) begin
      unique case (wb_adr_i)
        REG_CTRL: ctrl_d = {31'h0000_0000, merged[0]};
        REG_ADDR: addr_d = merged[23:0];
        REG_WDATA: wdata_d = merged[15:0];
        // Either half may be loaded at any time
        REG_PWD_LO: pwd_d[31:0] = merged;
        REG_PWD_HI: pwd_d[63:32] = merged;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
      addr_q <= ADDR_X;
      wdata_q <= D_00;
      pwd_q <= PWD_RESET;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      pwd_q <= pwd_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end
  // Command sequencer
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    code_d = code_q;
    idx_d = idx_q;
    start_d = 1'b0;
    rdata_d = rdata_q;
    set_d = set_q;
    ext_d = ext_q;
    refused_d = refused_q;
    gap_d = (gap_q != '0) ? gap_q - GAP_W'(1) : gap_q;
    if (cmd_wr && (st_q != S_IDLE || wb_dat_i[2:0] == OP_BAD)) begin
      refused_d = 1'b1;
    end
    unique case (st_q)
      S_IDLE: if (cmd_wr && wb_dat_i[2:0] != OP_BAD) begin
        refused_d = 1'b0;
        op_d = flbp_op_type'(wb_dat_i[2:0]);
        code_d = wb_dat_i[CMD_CODE_LSB +: 8];
        idx_d = 4'h0;
        st_d = S_WAIT;
      end
      // Unlock held back until the spacing timer has run out
      S_WAIT: if (!(op_q == OP_UNLOCK && idx_q == 4'h0 && gap_q != '0)) begin
        start_d = 1'b1;
        st_d = S_RUN;
      end
      S_RUN: if (cyc_done) begin
        if (!cur.we) begin
          rdata_d = cyc_rdata;
        end
        if (cur.last) begin
          st_d = S_IDLE;
          // Reads of block zero now reach the set, not the array
          if (op_q == OP_ENTER) begin
            ext_d = ext_q || code_q == SET_EXT;
            set_d = set_q || code_q != SET_EXT;
          end
          // Exit ops drop their own flag
          set_d = set_d && op_q != OP_EXIT;
          ext_d = ext_d && op_q != OP_EXTEXIT;
          if (op_q == OP_UNLOCK) begin
            gap_d = GAP_W'(UNLOCK_GAP_CYC);
          end
        end else begin
          idx_d = idx_q + 4'h1;
          st_d = S_WAIT;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      op_q <= OP_ENTER;
      code_q <= 8'h00;
      idx_q <= 4'h0;
      start_q <= 1'b0;
      rdata_q <= D_00;
      set_q <= 1'b0;
      ext_q <= 1'b0;
      refused_q <= 1'b0;
      gap_q <= '0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      code_q <= code_d;
      idx_q <= idx_d;
      start_q <= start_d;
      rdata_q <= rdata_d;
      set_q <= set_d;
      ext_q <= ext_d;
      refused_q <= refused_d;
      gap_q <= gap_d;
    end
  end
  // Flash bus cycle engine
  flbp_cycle #(
    .SETUP_CYC(SETUP_CYC),
    .PULSE_CYC(PULSE_CYC),
    .HOLD_CYC(HOLD_CYC)
  ) u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_q),
    .req_i(cur),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .addr_o(flash_addr_o),
    .dq_o(flash_dq_o),
    .dq_oe_o(flash_dq_oe_o),
    .dq_i(flash_dq_i),
    .ce_n_o(flash_ce_n_o),
    .oe_n_o(flash_oe_n_o),
    .we_n_o(flash_we_n_o)
  );
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign flash_byte_n_o = ctrl_q[CTRL_WORD_BIT];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence enter_first;
    start_q && op_q == OP_ENTER && idx_q == 4'h0;
  endsequence
  sequence exit_done;
    cyc_done && st_q == S_RUN && op_q == OP_EXIT && cur.last;
  endsequence
  enter_unlock_a: assert property (
    enter_first |-> cur.data == D_AA && cur.addr == (ctrl_q[0] ? U1_X16 : U1_X8))
    else $error("entry does not open with AA at first unlock address");
  enter_code_a: assert property (
    start_q && op_q == OP_ENTER && idx_q == 4'h2 |-> cur.data[7:0] == code_q && cur.last)
    else $error("third entry cycle does not carry the set code");
  exit_clears_a: assert property (
    exit_done |-> cur.data == D_00 ##1 !set_q && st_q == S_IDLE)
    else $error("exit did not end with 00 or set still active");
  prog_opens_a: assert property (
    start_q && op_q == OP_PROG && idx_q == 4'h0 |-> cur.data == D_A0 && !cur.last)
    else $error("program does not open with A0");
  unlock_gap_a: assert property (
    st_q == S_WAIT && op_q == OP_UNLOCK && idx_q == 4'h0 && gap_q != '0 |=> !start_q)
    else $error("unlock started before spacing expired");
  unlock_len_a: assert property (
    start_q && op_q == OP_UNLOCK && cur.last |-> cur.data == D_29 &&
    idx_q == (ctrl_q[0] ? 4'h6 : 4'ha))
    else $error("unlock sequence has wrong length or closing code");
  upper_zero_a: assert property (
    start_q && cur.we && !(op_q == OP_PROG && idx_q == 4'h1) &&
    !(op_q == OP_UNLOCK && ctrl_q[0]) |-> cur.data[15:8] == 8'h00)
    else $error("command cycle drives upper data byte");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held longer than one cycle");
endmodule // flbp_ctrl

//--- rtl/flbp_pkg.sv
package flbp_pkg;
  // Flash bus widths
  localparam int FLBP_AW = 24;
  localparam int FLBP_DW = 16;
  // Unlock addresses, byte and word mode
  localparam logic [23:0] U1_X8 = 24'h00_0aaa;
  localparam logic [23:0] U2_X8 = 24'h00_0555;
  localparam logic [23:0] U1_X16 = 24'h00_0555;
  localparam logic [23:0] U2_X16 = 24'h00_02aa;
  localparam logic [23:0] ADDR_X = 24'h00_0000;
  // Command data values
  localparam logic [15:0] D_AA = 16'h00aa;
  localparam logic [15:0] D_55 = 16'h0055;
  localparam logic [15:0] D_90 = 16'h0090;
  localparam logic [15:0] D_00 = 16'h0000;
  localparam logic [15:0] D_A0 = 16'h00a0;
  localparam logic [15:0] D_80 = 16'h0080;
  localparam logic [15:0] D_30 = 16'h0030;
  localparam logic [15:0] D_25 = 16'h0025;
  localparam logic [15:0] D_03 = 16'h0003;
  localparam logic [15:0] D_29 = 16'h0029;
  // Command set codes
  localparam logic [7:0] SET_LOCKREG = 8'h40;
  localparam logic [7:0] SET_PWD = 8'h60;
  localparam logic [7:0] SET_NVPB = 8'hc0;
  localparam logic [7:0] SET_PBLK = 8'h50;
  localparam logic [7:0] SET_VOL = 8'he0;
  localparam logic [7:0] SET_EXT = 8'h88;
  // Password portions per mode
  localparam logic [3:0] PWD_N_X8 = 4'h8;
  localparam logic [3:0] PWD_N_X16 = 4'h4;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int UNLOCK_GAP_NS = 6000;
  localparam int UNLOCK_GAP_CYC = (UNLOCK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W = 8;
  // Wishbone register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_PWD_LO = 8'h18;
  localparam logic [7:0] REG_PWD_HI = 8'h1c;
  // Field positions and reset values
  localparam int CTRL_WORD_BIT = 0;
  localparam int CMD_CODE_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SET = 1;
  localparam int STAT_EXT = 2;
  localparam int STAT_REFUSED = 3;
  localparam int STAT_BIT0 = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [63:0] PWD_RESET = 64'hffff_ffff_ffff_ffff;

  // Software command operations
  typedef enum logic [2:0] {
    OP_ENTER = 3'b000,
    OP_EXIT = 3'b001,
    OP_PROG = 3'b010,
    OP_READ = 3'b011,
    OP_CLRALL = 3'b100,
    OP_UNLOCK = 3'b101,
    OP_EXTEXIT = 3'b110,
    OP_BAD = 3'b111
  } flbp_op_type;

  // Sequencer states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_RUN = 2'b10
  } flbp_state_type;

  // Bus cycle engine states
  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_SETUP = 2'b01,
    C_PULSE = 2'b10,
    C_HOLD = 2'b11
  } flbp_cst_type;

  // One flash bus cycle
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic we;
    logic last;
  } flbp_cyc_type;
endpackage

//--- rtl/flbp_cycle.sv
`timescale 1ns/100ps
module flbp_cycle #(
  parameter int SETUP_CYC = 1,
  parameter int PULSE_CYC = 3,
  parameter int HOLD_CYC = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request from sequencer
  input wire logic start_i,
  input wire flbp_pkg::flbp_cyc_type req_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  // Flash pins
  output logic [23:0] addr_o,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  input wire logic [15:0] dq_i,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o
);
  import flbp_pkg::*;

  // Synchroniser delay needs a strobe of at least three cycles
  if (PULSE_CYC < 3 || PULSE_CYC > 15 || SETUP_CYC < 1 || SETUP_CYC > 15 ||
      HOLD_CYC < 1 || HOLD_CYC > 15) begin : g_bad_timing
    $error("flbp_cycle: timing parameters out of range");
  end

  flbp_cst_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [23:0] addr_q, addr_d;
  logic [15:0] dq_q, dq_d, rd_q, rd_d;
  logic oe_q, oe_d, ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, done_q, done_d;
  logic [15:0] dq_meta_q, dq_sync_q;

  // Two-stage input synchroniser
  always_ff @(posedge clk_i) begin
    dq_meta_q <= dq_i;
    dq_sync_q <= dq_meta_q;
  end

  // Cycle phase sequencing
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    dq_d = dq_q;
    rd_d = rd_q;
    oe_d = oe_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    done_d = 1'b0;
    unique case (st_q)
      C_IDLE: if (start_i) begin
        addr_d = req_i.addr;
        dq_d = req_i.data;
        oe_d = req_i.we;
        ce_n_d = 1'b0;
        cnt_d = 4'(SETUP_CYC - 1);
        st_d = C_SETUP;
      end
      C_SETUP: if (cnt_q == 4'h0) begin
        we_n_d = ~oe_q;
        oe_n_d = oe_q;
        cnt_d = 4'(PULSE_CYC - 1);
        st_d = C_PULSE;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
      C_PULSE: if (cnt_q == 4'h0) begin
        if (!oe_q) begin
          rd_d = dq_sync_q;
        end
        we_n_d = 1'b1;
        oe_n_d = 1'b1;
        cnt_d = 4'(HOLD_CYC - 1);
        st_d = C_HOLD;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
      C_HOLD: if (cnt_q == 4'h0) begin
        ce_n_d = 1'b1;
        oe_d = 1'b0;
        done_d = 1'b1;
        st_d = C_IDLE;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
    endcase
  end

  // Cycle registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= C_IDLE;
      cnt_q <= 4'h0;
      addr_q <= ADDR_X;
      dq_q <= D_00;
      rd_q <= D_00;
      oe_q <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      rd_q <= rd_d;
      oe_q <= oe_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
  assign rdata_o = rd_q;
  assign addr_o = addr_q;
  assign dq_o = dq_q;
  assign dq_oe_o = oe_q;
  assign ce_n_o = ce_n_q;
  assign oe_n_o = oe_n_q;
  assign we_n_o = we_n_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence cyc_finish;
    ##[6:46] done_q;
  endsequence
  cycle_done_a: assert property (st_q == C_IDLE && start_i |-> cyc_finish)
    else $error("bus cycle did not finish in time");
  we_strobe_a: assert property (!we_n_q |-> !ce_n_q && oe_q && oe_n_q)
    else $error("write strobe without chip select or drive");
endmodule // flbp_cycle

//--- dv/flbp_flash_model.sv
`timescale 1ns/100ps
module flbp_flash_model (
  // Flash pins from the controller
  input wire logic [23:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic byte_n_i,
  // Global lock bit, 1 = unlocked
  input wire logic glock_i,
  // Data the device puts on the bus
  output logic [15:0] dq_o
);
  logic [7:0] set_q, wd;
  logic [1:0] step_q;
  logic ext_q, a0_q, x90_q, c80_q, unlocked_q;
  logic [15:0] lockreg_q, last_q, rd, u1, u2, nvpb_q, vol_q;
  logic [63:0] pwd_q, guess_q;
  logic [3:0] blk, pidx, unl_q, npw;
  int n_unl, n_ign;
  realtime t29;
  // Command cycles look at the low data byte and low address only
  assign wd = dq_i[7:0];
  assign u1 = byte_n_i ? 16'h0555 : 16'h0aaa;
  assign u2 = byte_n_i ? 16'h02aa : 16'h0555;
  assign blk = addr_i[19:16];
  assign pidx = byte_n_i ? {2'b00, addr_i[1:0]} : {1'b0, addr_i[2:0]};
  assign npw = byte_n_i ? 4'h4 : 4'h8;
  initial begin
    {set_q, step_q, ext_q, a0_q, x90_q, c80_q, unlocked_q, unl_q} = '0;
    {pwd_q, nvpb_q, vol_q, lockreg_q} = '1;
    guess_q = '0;
    last_q = 16'h5a5a;
    n_unl = 0;
    n_ign = 0;
    t29 = -1.0e9;
  end
  // Write cycles, decoded at the rising edge of write enable
  always @(posedge we_n_i) begin
    if (!ce_n_i) begin
      if (a0_q) begin
        a0_q = 1'b0;
        case (set_q)
          8'h40: lockreg_q = dq_i;
          8'h60: if (byte_n_i) pwd_q[16*pidx +: 16] = dq_i; else pwd_q[8*pidx +: 8] = wd;
          8'hc0: if (wd == 8'h00) nvpb_q[blk] = 1'b0;
          8'he0: vol_q[blk] = wd[0];
          default: ;
        endcase
      end else if (unl_q != 0) begin
        if (unl_q == 1) unl_q = (wd == 8'h03) ? 4'h2 : 4'h0;
        else if (unl_q < npw + 2) begin
          if (byte_n_i) guess_q[16*pidx +: 16] = dq_i; else guess_q[8*pidx +: 8] = wd;
          unl_q = unl_q + 1;
        end else begin
          unlocked_q = (wd == 8'h29) && (guess_q == pwd_q);
          t29 = $realtime;
          unl_q = 0;
        end
      end else if (step_q == 2'd2) begin
        step_q = 0;
        if (addr_i[15:0] == u1 && wd == 8'h90) x90_q = 1'b1;
        else if (addr_i[15:0] == u1 && wd == 8'h88) ext_q = 1'b1;
        else if (addr_i[15:0] == u1) set_q = wd;
      end else if (step_q == 2'd1) step_q = (addr_i[15:0] == u2 && wd == 8'h55) ? 2'd2 : 2'd0;
      else if (addr_i[15:0] == u1 && wd == 8'haa) step_q = 2'd1;
      else if (x90_q) begin
        x90_q = 1'b0;
        if (wd == 8'h00) {set_q, ext_q} = '0;
      end else if (wd == 8'h90) x90_q = 1'b1;
      else if (wd == 8'ha0 && set_q != 0) a0_q = 1'b1;
      else if (wd == 8'h80 && set_q == 8'hc0) c80_q = 1'b1;
      else if (wd == 8'h30 && c80_q) begin
        c80_q = 1'b0;
        nvpb_q = 16'h0000;
        if (glock_i) nvpb_q = 16'hffff;
      end else if (wd == 8'h25 && set_q == 8'h60) begin
        n_unl++;
        if ($realtime - t29 < 6000.0) n_ign++;
        else {unl_q, unlocked_q} = {4'h1, 1'b0}; // New attempt starts locked
      end
    end
  end
  // Read data by active set; lock register and password sets answer in block zero only
  always_comb begin
    case (set_q)
      8'h40: rd = lockreg_q;
      8'h60: rd = byte_n_i ? pwd_q[16*pidx +: 16] : {8'h00, pwd_q[8*pidx +: 8]};
      8'hc0: rd = {15'h0000, nvpb_q[blk]};
      8'he0: rd = {15'h0000, vol_q[blk]};
      default: rd = addr_i[15:0] ^ 16'h3c3c;
    endcase
    if ((set_q == 8'h40 || set_q == 8'h60) && blk != 0) rd = addr_i[15:0] ^ 16'h3c3c;
  end
  // Released bus shows the inverse of the last value
  always @(posedge oe_n_i) last_q = rd;
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last_q;
endmodule // flbp_flash_model

//--- dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import flbp_pkg::*;
  localparam logic [63:0] PW = 64'h5aa5_3cc3_0ff0_9669;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, foe, ce_n, oe_n, we_n, byte_n, glock;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat, wb_dat_o, wb_rd;
  logic [3:0] wb_sel;
  logic [23:0] fa;
  logic [15:0] fdo, fdi, mdq;
  int err_count, n_tests;
  // Wire level: controller when enabled, else the device
  assign fdi = foe ? fdo : mdq;
  flbp_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .flash_addr_o(fa), .flash_dq_o(fdo),
    .flash_dq_oe_o(foe), .flash_dq_i(fdi), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
    .flash_we_n_o(we_n), .flash_byte_n_o(byte_n));
  flbp_flash_model u_flash (.addr_i(fa), .dq_i(fdo), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .byte_n_i(byte_n), .glock_i(glock), .dq_o(mdq));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hf;
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    wb_rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // Issue a command and wait until the controller is idle
  task automatic cmd(input logic [2:0] op, input logic [7:0] code, input logic [23:0] a,
                     input logic [15:0] d);
    wb(1'b1, REG_ADDR, {8'h00, a});
    wb(1'b1, REG_WDATA, {16'h0000, d});
    wb(1'b1, REG_CMD, {16'h0000, code, 5'h00, op});
    do wb(1'b0, REG_STATUS, 32'h0000_0000); while (wb_rd[STAT_BUSY] !== 1'b0);
  endtask
  // Read a flash location and compare the returned word
  task automatic rdchk(input logic [23:0] a, input logic [15:0] exp);
    cmd(OP_READ, 8'h00, a, 16'h0000);
    wb(1'b0, REG_RDATA, 32'h0000_0000);
    chk(32'(wb_rd[15:0]), 32'(exp), "read data");
  endtask
  task automatic t_reset;
    wb(1'b0, REG_CTRL, 32'h0000_0000);
    chk(wb_rd, CTRL_RESET, "ctrl reset");
    wb(1'b0, REG_PWD_LO, 32'h0000_0000);
    chk(wb_rd, PWD_RESET[31:0], "pwd lo reset");
    wb(1'b0, REG_PWD_HI, 32'h0000_0000);
    chk(wb_rd, PWD_RESET[63:32], "pwd hi reset");
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk(wb_rd, 32'h0000_0000, "unmapped");
    chk(32'({ce_n, we_n, oe_n, foe}), 32'(4'he), "idle pins");
  endtask
  task automatic t_sets;
    logic [7:0] codes [5];
    codes = '{SET_LOCKREG, SET_PWD, SET_NVPB, SET_PBLK, SET_VOL};
    foreach (codes[i]) begin
      cmd(OP_ENTER, codes[i], 24'h00_0000, 16'h0000);
      chk(32'(u_flash.set_q), 32'(codes[i]), "set entered");
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      chk(32'(wb_rd[STAT_SET]), 32'h0000_0001, "set flag");
      cmd(OP_EXIT, 8'h00, 24'h00_0000, 16'h0000);
      chk(32'(u_flash.set_q), 32'h0000_0000, "set left");
    end
    cmd(OP_ENTER, SET_LOCKREG, 24'h00_0000, 16'h0000);
    cmd(OP_PROG, 8'h00, 24'h00_0000, 16'hffc5);
    chk(32'(u_flash.lockreg_q), 32'h0000_ffc5, "lock reg");
    rdchk(24'h00_0000, 16'hffc5);
    cmd(OP_EXIT, 8'h00, 24'h00_0000, 16'h0000);
  endtask
  task automatic t_prot;
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    chk(32'(byte_n), 32'h0000_0001, "word mode pin");
    cmd(OP_ENTER, SET_NVPB, 24'h00_0000, 16'h0000);
    chk(32'(u_flash.set_q), 32'(SET_NVPB), "word entry");
    cmd(OP_PROG, 8'h00, 24'h03_1234, 16'h0000);
    rdchk(24'h03_0abc, 16'h0000);
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(32'(wb_rd[STAT_BIT0]), 32'h0000_0000, "status bit0");
    rdchk(24'h02_0000, 16'h0001);
    cmd(OP_CLRALL, 8'h00, 24'h00_0000, 16'h0000);
    rdchk(24'h03_0abc, 16'h0001);
    cmd(OP_PROG, 8'h00, 24'h03_1234, 16'h0000);
    glock = 1'b0;
    cmd(OP_CLRALL, 8'h00, 24'h00_0000, 16'h0000);
    rdchk(24'h03_0abc, 16'h0000);
    glock = 1'b1;
    cmd(OP_EXIT, 8'h00, 24'h00_0000, 16'h0000);
    cmd(OP_ENTER, SET_VOL, 24'h00_0000, 16'h0000);
    cmd(OP_PROG, 8'h00, 24'h05_0000, 16'h0000);
    rdchk(24'h05_0010, 16'h0000);
    cmd(OP_PROG, 8'h00, 24'h05_0000, 16'h0001);
    rdchk(24'h05_0010, 16'h0001);
    cmd(OP_EXIT, 8'h00, 24'h00_0000, 16'h0000);
    cmd(OP_ENTER, SET_EXT, 24'h00_0000, 16'h0000);
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(32'({wb_rd[STAT_EXT], u_flash.ext_q}), 32'h0000_0003, "ext entered");
    cmd(OP_EXTEXIT, 8'h00, 24'h00_0000, 16'h0000);
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(32'({wb_rd[STAT_EXT], u_flash.ext_q}), 32'h0000_0000, "ext left");
    wb(1'b1, REG_CTRL, 32'h0000_0000);
    wb(1'b1, REG_CMD, 32'h0000_0007);
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(32'(wb_rd[STAT_REFUSED]), 32'h0000_0001, "refused flag");
  endtask
  task automatic t_pwd;
    cmd(OP_ENTER, SET_PWD, 24'h00_0000, 16'h0000);
    for (int k = 7; k >= 0; k--) cmd(OP_PROG, 8'h00, 24'(k), {8'h00, PW[8*k +: 8]});
    chk(u_flash.pwd_q[31:0], PW[31:0], "pwd low");
    chk(u_flash.pwd_q[63:32], PW[63:32], "pwd high");
    for (int k = 0; k < 8; k++) rdchk(24'(k), {8'h00, PW[8*k +: 8]});
    wb(1'b1, REG_PWD_LO, PW[31:0]);
    wb(1'b1, REG_PWD_HI, PW[63:32]);
    cmd(OP_UNLOCK, 8'h00, 24'h00_0000, 16'h0000);
    chk(32'(u_flash.unlocked_q), 32'h0000_0001, "byte unlock");
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    cmd(OP_UNLOCK, 8'h00, 24'h00_0000, 16'h0000);
    chk(32'(u_flash.unlocked_q), 32'h0000_0001, "word unlock");
    wb(1'b1, REG_PWD_LO, ~PW[31:0]);
    cmd(OP_UNLOCK, 8'h00, 24'h00_0000, 16'h0000);
    chk(32'(u_flash.unlocked_q), 32'h0000_0000, "wrong password");
    chk(32'(u_flash.n_unl), 32'h0000_0003, "unlock count");
    chk(32'(u_flash.n_ign), 32'h0000_0000, "unlock spacing");
    cmd(OP_EXIT, 8'h00, 24'h00_0000, 16'h0000);
    wb(1'b1, REG_CTRL, 32'h0000_0000);
  endtask
  task automatic summarize;
    $display("Counts: %0d mismatches in %0d comparisons", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {err_count, n_tests} = '0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} = '0;
    glock = 1'b1;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_sets;
    t_prot;
    t_pwd;
    summarize;
  end
  // Watchdog
  initial begin
    #1_000_000;
    err_count++;
    summarize;
  end
endmodule // testbench
